// file: rtl/ddc_pkg.sv
// Package: register map, field layout, reset values and timing for ddc
package ddc_pkg;
  // -----------------------------------------------------------------
  // Register word offsets and byte addresses
  // -----------------------------------------------------------------
  localparam logic [7:0] DDC_OFF_SETUP_TWO = 8'ha8;
  localparam logic [7:0] DDC_OFF_PERI_SETUP = 8'haa;
  localparam logic [7:0] DDC_IDX_PERI_SETUP = 8'haa;
  localparam logic [9:0] DDC_ADR_SETUP_TWO = 10'h2a0;
  localparam logic [9:0] DDC_ADR_PERI_SETUP = 10'h2a8;
  localparam logic [9:0] DDC_ADR_IRQ_STAT = 10'h300;
  localparam logic [9:0] DDC_ADR_IRQ_MASK = 10'h304;
  localparam logic [9:0] DDC_ADR_TICKLE = 10'h308;
  localparam logic [9:0] DDC_ADR_STATUS = 10'h30c;
  // -----------------------------------------------------------------
  // Reset values and writable masks
  // -----------------------------------------------------------------
  localparam logic [31:0] DDC_RST_SETUP_TWO = 32'h0000_0000;
  localparam logic [31:0] DDC_RST_PERI_SETUP = 32'h4000_0000;
  localparam logic [31:0] DDC_WMASK_SETUP_TWO = 32'h7fff_ffff;
  localparam logic [31:0] DDC_WMASK_PERI_SETUP = 32'h43e0_0000;
  // -----------------------------------------------------------------
  // Field positions, second setup word
  // -----------------------------------------------------------------
  localparam int DDC_MAXF_HI = 30;
  localparam int DDC_MAXF_LO = 16;
  localparam int DDC_SLEEP_HI = 15;
  localparam int DDC_SLEEP_LO = 14;
  localparam int DDC_AUTO_CUR = 13;
  localparam int DDC_AUTO_VOLT = 12;
  localparam int DDC_LP_SEL = 11;
  localparam int DDC_CLKSRC_HI = 10;
  localparam int DDC_CLKSRC_LO = 9;
  localparam int DDC_OCLK_EN = 8;
  localparam int DDC_OCLK_RATE_HI = 7;
  localparam int DDC_OCLK_RATE_LO = 5;
  localparam int DDC_WD_EN = 4;
  localparam int DDC_WD_INT_HI = 3;
  localparam int DDC_WD_INT_LO = 2;
  localparam int DDC_WD_SRC = 1;
  localparam int DDC_WD_RESP = 0;
  // Peripheral setup word
  localparam int DDC_DITHER_DIS = 30;
  localparam int DDC_ILIM_HI = 25;
  localparam int DDC_ILIM_LO = 22;
  localparam int DDC_ILIM_EN = 21;
  // Clock source codes
  localparam logic [1:0] DDC_CLKSRC_INT = 2'h0;
  localparam logic [1:0] DDC_CLKSRC_EXT = 2'h3;
  // Interrupt bits
  localparam int DDC_IRQ_WD = 0;
  localparam int DDC_IRQ_SLEEP = 1;
  localparam int DDC_IRQ_W = 2;
  // -----------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------
  localparam longint DDC_CLK_HZ = 125_000_000;
  localparam longint DDC_SLEEP_US0 = 50;
  localparam longint DDC_SLEEP_US1 = 200;
  localparam longint DDC_SLEEP_MS2 = 20;
  localparam longint DDC_SLEEP_MS3 = 200;
  localparam longint DDC_SLEEP_CYC0 = DDC_SLEEP_US0 * DDC_CLK_HZ / 1_000_000;
  localparam longint DDC_SLEEP_CYC1 = DDC_SLEEP_US1 * DDC_CLK_HZ / 1_000_000;
  localparam longint DDC_SLEEP_CYC2 = DDC_SLEEP_MS2 * DDC_CLK_HZ / 1_000;
  localparam longint DDC_SLEEP_CYC3 = DDC_SLEEP_MS3 * DDC_CLK_HZ / 1_000;
  localparam longint DDC_WDP_MS0 = 100;
  localparam longint DDC_WDP_MS1 = 200;
  localparam longint DDC_WDP_MS2 = 500;
  localparam longint DDC_WDP_MS3 = 1000;
  localparam longint DDC_WDB_S0 = 1;
  localparam longint DDC_WDB_S1 = 2;
  localparam longint DDC_WDB_S2 = 3;
  localparam longint DDC_WDB_S3 = 10;
  localparam longint DDC_WDP_CYC0 = DDC_WDP_MS0 * DDC_CLK_HZ / 1_000;
  localparam longint DDC_WDB_CYC0 = DDC_WDB_S0 * DDC_CLK_HZ;
  // Outside clock rate at code 0, doubling per code
  localparam int DDC_OCLK_BASE_KHZ = 8;
  // Duty result width (fraction of full scale)
  localparam int DDC_DUTY_W = 16;
  localparam logic [DDC_DUTY_W-1:0] DDC_DUTY_FULL = 16'hffff;
endpackage

// file: rtl/ddc_regs.sv
// Configuration register bank for a sensorless motor drive, Wishbone slave
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ns
module ddc_regs
  import ddc_pkg::*;
#(
  parameter longint SLEEP_CYC2 = DDC_SLEEP_CYC2,
  parameter longint SLEEP_CYC3 = DDC_SLEEP_CYC3,
  parameter longint WD_PIN_CYC0 = DDC_WDP_CYC0,
  parameter longint WD_BUS_CYC0 = DDC_WDB_CYC0,
  parameter int FREQ_W = 15
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Speed input, tickle pin and measured frequency
  input wire logic speed_low_i,
  input wire logic wd_pin_i,
  input wire logic [FREQ_W-1:0] meas_freq_i,
  // Control outputs
  output logic [DDC_DUTY_W-1:0] freq_duty_o,
  output logic sleep_req_o,
  output logic standby_req_o,
  output logic auto_current_amp_gain_o,
  output logic auto_volt_meas_gain_o,
  output logic ext_clk_sel_o,
  output logic outside_clock_enable_o,
  output logic [10:0] outside_clock_khz_o,
  output logic clock_dithering_o,
  output logic [12:0] bus_ilim_ma_o,
  output logic bus_ilim_en_o,
  output logic wd_fault_o,
  output logic power_hiz_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0] setup_two_r; // Second setup word
  logic [31:0] peri_setup_r; // Peripheral setup word
  logic [DDC_IRQ_W-1:0] irq_stat_r; // Sticky event bits
  logic [DDC_IRQ_W-1:0] irq_mask_r; // Event enables
  logic wd_latch_r; // Latched watchdog fault (Hi-Z)
  logic [31:0] bus_rd; // Read mux
  logic acc; // Access this cycle
  logic wr; // Write strobe
  logic bus_tickle; // Bus tickle strobe
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = acc & wb_we_i;
  assign bus_tickle = wr & (wb_adr_i == DDC_ADR_TICKLE);
  // Merge write data under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] msk);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (wb_sel_i[b]) begin
        res[b*8 +: 8] = wb_dat_i[b*8 +: 8];
      end
    end
    return (res & msk) | (old & ~msk);
  endfunction
  // ---------------------------------------------------------------
  // Pin synchronisers (three flops, change on second/third agree)
  // ---------------------------------------------------------------
  logic [2:0] spd_s_r;
  logic [2:0] wdp_s_r;
  logic spd_low_r; // Filtered speed-low level
  logic wdp_r; // Filtered tickle pin level
  logic wdp_d_r; // Previous filtered tickle level
  // Shift pins into synchronisers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      spd_s_r <= 3'h0;
      wdp_s_r <= 3'h0;
    end else begin
      spd_s_r <= {spd_s_r[1:0], speed_low_i};
      wdp_s_r <= {wdp_s_r[1:0], wd_pin_i};
    end
  end
  // Accept a change once stages two and three agree
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      spd_low_r <= 1'b0;
      wdp_r <= 1'b0;
      wdp_d_r <= 1'b0;
    end else begin
      if (spd_s_r[1] == spd_s_r[2]) begin
        spd_low_r <= spd_s_r[2];
      end
      if (wdp_s_r[1] == wdp_s_r[2]) begin
        wdp_r <= wdp_s_r[2];
      end
      wdp_d_r <= wdp_r;
    end
  end
  // ---------------------------------------------------------------
  // Wishbone register access
  // ---------------------------------------------------------------
  // Acknowledge one cycle after the request, drop the next cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? bus_rd : 32'h0000_0000;
    end
  end
  // Setup words, reserved bits kept at zero
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      setup_two_r <= DDC_RST_SETUP_TWO;
      peri_setup_r <= DDC_RST_PERI_SETUP;
    end else if (wr) begin
      if (wb_adr_i == DDC_ADR_SETUP_TWO) begin
        setup_two_r <= merge(setup_two_r, DDC_WMASK_SETUP_TWO);
      end
      if (wb_adr_i == DDC_ADR_PERI_SETUP) begin
        peri_setup_r <= merge(peri_setup_r, DDC_WMASK_PERI_SETUP);
      end
    end
  end
  // Read mux; unmapped addresses read zero
  always_comb begin
    unique case (wb_adr_i)
      DDC_ADR_SETUP_TWO: bus_rd = setup_two_r;
      DDC_ADR_PERI_SETUP: bus_rd = peri_setup_r;
      DDC_ADR_IRQ_STAT: bus_rd = {30'h0, irq_stat_r};
      DDC_ADR_IRQ_MASK: bus_rd = {30'h0, irq_mask_r};
      DDC_ADR_STATUS: bus_rd = {30'h0, wd_latch_r, sleep_req_o};
      default: bus_rd = 32'h0000_0000;
    endcase
  end
  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  logic [1:0] sleep_code;
  logic [1:0] wd_code;
  logic wd_en;
  logic wd_src;
  assign sleep_code = setup_two_r[DDC_SLEEP_HI:DDC_SLEEP_LO];
  assign wd_code = setup_two_r[DDC_WD_INT_HI:DDC_WD_INT_LO];
  assign wd_en = setup_two_r[DDC_WD_EN];
  assign wd_src = setup_two_r[DDC_WD_SRC];
  // Sleep entry time in cycles for the selected code
  logic [31:0] sleep_lim;
  always_comb begin
    unique case (sleep_code)
      2'h0: sleep_lim = 32'(DDC_SLEEP_CYC0);
      2'h1: sleep_lim = 32'(DDC_SLEEP_CYC1);
      2'h2: sleep_lim = 32'(SLEEP_CYC2);
      2'h3: sleep_lim = 32'(SLEEP_CYC3);
    endcase
  end
  // Watchdog interval: pin scale or bus scale (1,2,3,10 s)
  logic [31:0] wd_lim;
  always_comb begin
    unique case ({wd_src, wd_code})
      3'h4: wd_lim = 32'(WD_PIN_CYC0);
      3'h5: wd_lim = 32'(WD_PIN_CYC0 * DDC_WDP_MS1 / DDC_WDP_MS0);
      3'h6: wd_lim = 32'(WD_PIN_CYC0 * DDC_WDP_MS2 / DDC_WDP_MS0);
      3'h7: wd_lim = 32'(WD_PIN_CYC0 * DDC_WDP_MS3 / DDC_WDP_MS0);
      3'h0: wd_lim = 32'(WD_BUS_CYC0);
      3'h1: wd_lim = 32'(WD_BUS_CYC0 * DDC_WDB_S1 / DDC_WDB_S0);
      3'h2: wd_lim = 32'(WD_BUS_CYC0 * DDC_WDB_S2 / DDC_WDB_S0);
      3'h3: wd_lim = 32'(WD_BUS_CYC0 * DDC_WDB_S3 / DDC_WDB_S0);
    endcase
  end
  // ---------------------------------------------------------------
  // Sleep entry timer
  // ---------------------------------------------------------------
  logic [31:0] low_cnt_r; // Cycles speed has stayed low
  logic lp_hit; // Low-power entry event
  assign lp_hit = spd_low_r & (low_cnt_r >= sleep_lim - 32'h1) &
                  ~(sleep_req_o | standby_req_o);
  // Count continuous low time, restart on any high
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      low_cnt_r <= 32'h0;
    end else if (!spd_low_r) begin
      low_cnt_r <= 32'h0;
    end else if (low_cnt_r < sleep_lim) begin
      low_cnt_r <= low_cnt_r + 32'h1;
    end
  end
  // Enter sleep or standby as selected; leave when speed rises
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sleep_req_o <= 1'b0;
      standby_req_o <= 1'b0;
    end else if (!spd_low_r) begin
      sleep_req_o <= 1'b0;
      standby_req_o <= 1'b0;
    end else if (lp_hit) begin
      sleep_req_o <= setup_two_r[DDC_LP_SEL];
      standby_req_o <= ~setup_two_r[DDC_LP_SEL];
    end
  end
  // ---------------------------------------------------------------
  // Host watchdog
  // ---------------------------------------------------------------
  logic [31:0] wd_cnt_r; // Cycles since last tickle
  logic tickle; // Valid tickle from selected source
  logic wd_exp; // Interval elapsed
  assign tickle = wd_src ? (wdp_r & ~wdp_d_r) : bus_tickle;
  assign wd_exp = wd_en & ~tickle & (wd_cnt_r >= wd_lim - 32'h1);
  // Restart on tickle, hold at zero while disabled
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wd_cnt_r <= 32'h0;
    end else if (!wd_en || tickle || wd_exp) begin
      wd_cnt_r <= 32'h0;
    end else begin
      wd_cnt_r <= wd_cnt_r + 32'h1;
    end
  end
  // Latch fault and Hi-Z only in latch mode; cleared by reset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wd_latch_r <= 1'b0;
    end else if (wd_exp && setup_two_r[DDC_WD_RESP]) begin
      wd_latch_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts: sticky status, write one to clear, set wins
  // ---------------------------------------------------------------
  logic [DDC_IRQ_W-1:0] ev;
  logic [DDC_IRQ_W-1:0] clr;
  assign ev = {lp_hit, wd_exp};
  assign clr = (wr && wb_adr_i == DDC_ADR_IRQ_STAT && wb_sel_i[0]) ?
               wb_dat_i[DDC_IRQ_W-1:0] : '0;

  // Status bits
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~clr) | ev;
    end
  end

  // Mask register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_mask_r <= '0;
    end else if (wr && wb_adr_i == DDC_ADR_IRQ_MASK && wb_sel_i[0]) begin
      irq_mask_r <= wb_dat_i[DDC_IRQ_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Derived control outputs
  // ---------------------------------------------------------------
  logic [FREQ_W-1:0] maxf;
  logic [FREQ_W+DDC_DUTY_W-1:0] num;
  logic [FREQ_W+DDC_DUTY_W-1:0] quo;
  assign maxf = setup_two_r[DDC_MAXF_HI:DDC_MAXF_LO];
  assign num = {meas_freq_i, DDC_DUTY_W'(0)};
  assign quo = (maxf == '0) ? '0 : num / (FREQ_W+DDC_DUTY_W)'(maxf);

  // Current limit in mA per code
  function automatic logic [12:0] ilim_ma(input logic [3:0] c);
    logic [12:0] t [16];
    t = '{13'd78, 13'd156, 13'd312, 13'd625, 13'd937, 13'd1250,
          13'd1562, 13'd1875, 13'd2187, 13'd2500, 13'd2812, 13'd3125,
          13'd3437, 13'd3750, 13'd4375, 13'd5000};
    return t[c];
  endfunction

  // Register every control output
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      freq_duty_o <= '0;
      auto_current_amp_gain_o <= 1'b0;
      auto_volt_meas_gain_o <= 1'b0;
      ext_clk_sel_o <= 1'b0;
      outside_clock_enable_o <= 1'b0;
      outside_clock_khz_o <= 11'h0;
      clock_dithering_o <= 1'b0;
      bus_ilim_ma_o <= 13'h0;
      bus_ilim_en_o <= 1'b0;
      wd_fault_o <= 1'b0;
      power_hiz_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      // Saturate at full command
      freq_duty_o <= (|quo[FREQ_W+DDC_DUTY_W-1:DDC_DUTY_W]) ?
                     DDC_DUTY_FULL : quo[DDC_DUTY_W-1:0];
      auto_current_amp_gain_o <= setup_two_r[DDC_AUTO_CUR];
      auto_volt_meas_gain_o <= setup_two_r[DDC_AUTO_VOLT];
      ext_clk_sel_o <= setup_two_r[DDC_CLKSRC_HI:DDC_CLKSRC_LO]
                       == DDC_CLKSRC_EXT;
      outside_clock_enable_o <= setup_two_r[DDC_OCLK_EN];
      outside_clock_khz_o <= 11'(DDC_OCLK_BASE_KHZ) <<
        setup_two_r[DDC_OCLK_RATE_HI:DDC_OCLK_RATE_LO];
      clock_dithering_o <= ~peri_setup_r[DDC_DITHER_DIS];
      bus_ilim_ma_o <=
        ilim_ma(peri_setup_r[DDC_ILIM_HI:DDC_ILIM_LO]);
      bus_ilim_en_o <= peri_setup_r[DDC_ILIM_EN];
      wd_fault_o <= irq_stat_r[DDC_IRQ_WD] | wd_latch_r;
      power_hiz_o <= wd_latch_r;
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_HIZ_ONLY_LATCH: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) wd_exp && !setup_two_r[DDC_WD_RESP] &&
    !wd_latch_r |=> !wd_latch_r)
    else $error("Hi-Z latched in report mode");
  AST_HIZ_FOLLOWS: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) wd_exp && setup_two_r[DDC_WD_RESP]
    |=> ##1 power_hiz_o)
    else $error("Hi-Z not set after latched fault");
  AST_WD_RESTART: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) tickle && wd_en |=> wd_cnt_r == 32'h0)
    else $error("Tickle did not restart watchdog");
  AST_WD_OFF: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) !wd_en |=> wd_cnt_r == 32'h0 &&
    !$rose(irq_stat_r[DDC_IRQ_WD]))
    else $error("Watchdog ran while disabled");
  AST_SLEEP_SEL: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) lp_hit |=> sleep_req_o ==
    $past(setup_two_r[DDC_LP_SEL]) && standby_req_o != sleep_req_o)
    else $error("Wrong low-power state entered");
  AST_SLEEP_CLR: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) !spd_low_r |=> !sleep_req_o && !standby_req_o)
    else $error("Low-power held with speed high");
  AST_DITHER: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) $rose(rst_n_i) |-> ##1 !clock_dithering_o)
    else $error("Dithering enabled out of reset");
  AST_ILIM_EN: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) ##1 bus_ilim_en_o ==
    $past(peri_setup_r[DDC_ILIM_EN]))
    else $error("Limit enable does not follow register");
  AST_ACK_DROP: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) wb_ack_o |=> !wb_ack_o)
    else $error("Ack held two cycles");
endmodule

// file: sim/ddc_host_model.sv
// Host model that tickles the watchdog pin at a fixed spacing
`timescale 1ns/1ns
module ddc_host_model (
  input wire logic ref_clk_i,
  input wire logic tick_en_i,
  input wire logic [15:0] gap_i,
  output logic wd_pin_o
);
  logic [15:0] cnt_r; // Cycles since the last tickle began
  // ---------------------------------------------------------------
  // Tickle spacing counter
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!tick_en_i) begin
      cnt_r <= 16'h0000; // Idle host sends nothing
    end else if (cnt_r >= gap_i - 16'h0001) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  // Four-cycle pulse so the synchroniser sees a clean rising edge
  assign wd_pin_o = tick_en_i && (cnt_r < 16'h0004);
endmodule

// file: sim/ddc_regs_tb_top.sv
// Self-checking testbench for the drive configuration register bank
`timescale 1ns/1ns
module ddc_regs_tb_top;
  import ddc_pkg::*;
  localparam int WP = 100; // Pin interval at code 0, shortened
  localparam int WB = 200; // Bus interval at code 0, shortened
  int lim[4] = '{6250, 25000, 200, 400}; // Sleep entry cycles
  int wl[8] = '{100, 200, 500, 1000, 200, 400, 600, 2000};
  int ilt[16] = '{78, 156, 312, 625, 937, 1250, 1562, 1875, 2187,
    2500, 2812, 3125, 3437, 3750, 4375, 5000}; // Limit in mA
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic spd = 1'b0; // Speed below threshold
  logic pin; // Tickle pin from the host model
  logic tick = 1'b0;
  logic [15:0] gap = 16'h0032;
  logic [14:0] mf = 15'h0000; // Measured frequency
  logic [15:0] duty;
  logic slp, stby, acg, avg, xsel, xen, dith, ilen, flt, hiz, irq;
  logic [10:0] khz;
  logic [12:0] ilim;
  logic [31:0] m_two; // Model of the second setup word
  logic [31:0] m_peri; // Model of the peripheral setup word
  int err_total = 0;
  int n_tests = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  ddc_regs #(.SLEEP_CYC2(200), .SLEEP_CYC3(400), .WD_PIN_CYC0(WP),
    .WD_BUS_CYC0(WB)) i_ddc_regs (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .speed_low_i(spd), .wd_pin_i(pin),
    .meas_freq_i(mf), .freq_duty_o(duty), .sleep_req_o(slp),
    .standby_req_o(stby), .auto_current_amp_gain_o(acg),
    .auto_volt_meas_gain_o(avg), .ext_clk_sel_o(xsel),
    .outside_clock_enable_o(xen), .outside_clock_khz_o(khz),
    .clock_dithering_o(dith), .bus_ilim_ma_o(ilim),
    .bus_ilim_en_o(ilen), .wd_fault_o(flt), .power_hiz_o(hiz),
    .irq_o(irq));
  ddc_host_model i_ddc_host_model (.ref_clk_i(ref_clk_i),
    .tick_en_i(tick), .gap_i(gap), .wd_pin_o(pin));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // Compare seen against expected and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One classic Wishbone cycle, held until ack is sampled
  task automatic bus(input logic [9:0] a, input logic w,
    input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
    @(posedge ref_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge ref_clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // Write and update the model with byte lanes and writable bits
  task automatic wr(input logic [9:0] a, input logic [31:0] d,
    input logic [3:0] s);
    logic [31:0] q, m;
    for (int i = 0; i < 4; i++) m[i*8+:8] = s[i] ? 8'hff : 8'h00;
    bus(a, 1'b1, d, s, q);
    if (a == DDC_ADR_SETUP_TWO) begin
      m = m & 32'h7fff_ffff;
      m_two = (m_two & ~m) | (d & m);
    end
    if (a == DDC_ADR_PERI_SETUP) begin
      m = m & 32'h43e0_0000;
      m_peri = (m_peri & ~m) | (d & m);
    end
  endtask
  // Read and compare against an expected word
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0000_0000, 4'hf, q);
    chk(q, e);
  endtask
  // Let registered outputs settle
  task automatic settle(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask
  // Pick a watched output by index
  function automatic logic pick(input int k);
    return (k == 0) ? flt : ((k == 1) ? slp : stby);
  endfunction
  // Count cycles until a watched output rises, bounded
  task automatic waitfor(input int k, output int n);
    n = 0;
    while (pick(k) !== 1'b1 && n < 30000) begin
      @(posedge ref_clk_i);
      n++;
    end
  endtask
  // Compare every configuration output with the model
  task automatic outs();
    logic [31:0] mx, dv;
    settle(20);
    mx = {17'h00000, m_two[30:16]};
    dv = (mx == 0) ? 32'h0 : ({17'h00000, mf} * 32'h1_0000) / mx;
    if (dv > 32'hffff) dv = 32'hffff;
    chk(duty, dv);
    chk(acg, m_two[13]);
    chk(avg, m_two[12]);
    chk(xsel, m_two[10:9] == 2'h3);
    chk(xen, m_two[8]);
    chk(khz, 32'h8 << m_two[7:5]);
    chk(dith, !m_peri[30]);
    chk(ilim, ilt[m_peri[25:22]]);
    chk(ilen, m_peri[21]);
  endtask
  // Print the counts and the verdict, then stop
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Cut a hang short
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    err_total++;
    finish_test();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    logic [31:0] d, q;
    d = $urandom(32'h02ee05df);
    m_two = 32'h0000_0000;
    m_peri = 32'h4000_0000;
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(DDC_ADR_SETUP_TWO, 32'h0000_0000);
    rd(DDC_ADR_PERI_SETUP, 32'h4000_0000);
    rd(10'h3fc, 32'h0000_0000);
    outs();
    // Field sweep with random neighbours and partial byte lanes
    for (int i = 0; i < 16; i++) begin
      mf <= 15'($urandom);
      d = $urandom;
      d[7:5] = i[2:0];
      d[10:9] = i[1:0];
      d[4] = 1'b0;
      if (i < 2) d[30:16] = 15'(i);
      wr(DDC_ADR_SETUP_TWO, d, (i == 5) ? 4'h6 : 4'hf);
      rd(DDC_ADR_SETUP_TWO, m_two);
      d = $urandom;
      d[25:22] = i[3:0];
      wr(DDC_ADR_PERI_SETUP, d, (i == 15) ? 4'h4 : 4'hf);
      rd(DDC_ADR_PERI_SETUP, m_peri);
      outs();
    end
    // Sleep entry times for every code, both low-power choices
    for (int i = 0; i < 4; i++) begin
      wr(DDC_ADR_SETUP_TWO, (i << 14) | ((i & 1) << 11), 4'hf);
      spd <= 1'b1;
      waitfor(((i & 1) != 0) ? 1 : 2, n);
      chk(n >= lim[i] && n <= lim[i] + 12, 1'b1);
      chk(((i & 1) != 0) ? stby : slp, 1'b0);
      spd <= 1'b0;
      settle(8);
      chk(slp | stby, 1'b0);
    end
    // Interrupt: raised event, masked, unmasked, cleared
    bus(DDC_ADR_IRQ_STAT, 1'b0, 32'h0, 4'hf, q);
    chk(q[1], 1'b1);
    chk(irq, 1'b0);
    wr(DDC_ADR_IRQ_MASK, 32'h0000_0003, 4'h1);
    settle(3);
    chk(irq, 1'b1);
    wr(DDC_ADR_IRQ_STAT, 32'h0000_0002, 4'h1);
    settle(3);
    chk(irq, 1'b0);
    // Watchdog expiry for every interval, pin then bus source
    for (int i = 0; i < 8; i++) begin
      wr(DDC_ADR_SETUP_TWO, 32'h10 | ((i % 4) << 2) | ((i / 4) << 1)
        ^ 32'h2, 4'hf);
      waitfor(0, n);
      chk(n >= wl[i] - 2 && n <= wl[i] + 8, 1'b1);
      settle(3);
      chk({irq, hiz}, 2'b10);
      wr(DDC_ADR_SETUP_TWO, 32'h0, 4'hf);
      wr(DDC_ADR_IRQ_STAT, 32'h0000_0001, 4'h1);
      settle(300);
      chk(flt, 1'b0);
    end
    // Pin tickles keep it alive, then are ignored on bus source
    tick <= 1'b1;
    wr(DDC_ADR_SETUP_TWO, 32'h0000_0012, 4'hf);
    settle(600);
    chk(flt, 1'b0);
    wr(DDC_ADR_SETUP_TWO, 32'h0000_0010, 4'hf);
    waitfor(0, n);
    chk(n <= WB + 8, 1'b1);
    tick <= 1'b0;
    wr(DDC_ADR_SETUP_TWO, 32'h0, 4'hf);
    wr(DDC_ADR_IRQ_STAT, 32'h0000_0001, 4'h1);
    // Bus tickles keep it alive
    wr(DDC_ADR_SETUP_TWO, 32'h0000_0010, 4'hf);
    for (int i = 0; i < 8; i++) begin
      settle(100);
      wr(DDC_ADR_TICKLE, $urandom, 4'hf);
    end
    chk(flt, 1'b0);
    // Latch response: Hi-Z holds until reset
    wr(DDC_ADR_SETUP_TWO, 32'h0000_0011, 4'hf);
    waitfor(0, n);
    settle(3);
    chk(hiz, 1'b1);
    wr(DDC_ADR_IRQ_STAT, 32'h0000_0001, 4'h1);
    wr(DDC_ADR_SETUP_TWO, 32'h0, 4'hf);
    settle(3);
    chk({flt, hiz}, 2'b11);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    m_two = 32'h0000_0000;
    m_peri = 32'h4000_0000;
    settle(3);
    chk({flt, hiz}, 2'b00);
    outs();
    finish_test();
  end
endmodule
